// *** rtl/data_move_pkg.sv ***
// Shared constants and types for the data-movement instruction group
package data_move_pkg;

  // Widths of the instruction word, data path, file address and retire counter
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int COUNT_W = 16;

  // Opcode match masks and patterns (pattern = word & mask)
  localparam logic [INSTR_W-1:0] COPY_MASK     = 14'h3f00;
  localparam logic [INSTR_W-1:0] COPY_PATTERN  = 14'h0800;
  localparam logic [INSTR_W-1:0] STORE_MASK    = 14'h3f80;
  localparam logic [INSTR_W-1:0] STORE_PATTERN = 14'h0080;
  localparam logic [INSTR_W-1:0] LOAD_MASK     = 14'h3c00;
  localparam logic [INSTR_W-1:0] LOAD_PATTERN  = 14'h3000;
  localparam logic [INSTR_W-1:0] IDLE_MASK     = 14'h3f9f;
  localparam logic [INSTR_W-1:0] IDLE_PATTERN  = 14'h0000;

  // Don't-care field of the immediate load word
  localparam logic [INSTR_W-1:0] LOAD_DC_MASK  = 14'h0300;

  // Field positions inside the instruction word
  localparam int DEST_BIT = 7;
  localparam int FILE_LSB = 0;
  localparam int LIT_LSB  = 0;

  // Destination encoding of the copy instruction
  localparam logic DEST_ACCUM = 1'b0;

  // Reset values and retire counter step
  localparam logic [DATA_W-1:0]  ACCUM_RESET = 8'h00;
  localparam logic               ZERO_RESET  = 1'b0;
  localparam logic [DATA_W-1:0]  FILE_RESET  = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_STEP  = 16'h0001;

  // Kind of the last instruction taken
  typedef enum logic [2:0] {
    OP_NONE,
    OP_COPY,
    OP_STORE,
    OP_LOAD,
    OP_IDLE,
    OP_OTHER
  } op_type;

endpackage : data_move_pkg

// *** rtl/file_reg_bank.sv ***
// File register bank with one write port, one read port and a peek port
`timescale 1ns/1ns
`default_nettype none

module file_reg_bank #(
  parameter int DEPTH = 128
) (
  input  wire logic                               core_clk,  // Core clock
  input  wire logic                               reset,     // Async reset, active high
  input  wire logic                               wr_en,     // Write strobe
  input  wire logic [data_move_pkg::ADDR_W-1:0]   wr_addr,   // Write address
  input  wire logic [data_move_pkg::DATA_W-1:0]   wr_data,   // Write data
  input  wire logic [data_move_pkg::ADDR_W-1:0]   rd_addr,   // Read address
  output logic      [data_move_pkg::DATA_W-1:0]   rd_data,   // Read data, same cycle
  input  wire logic [data_move_pkg::ADDR_W-1:0]   peek_addr, // Observation address
  output logic      [data_move_pkg::DATA_W-1:0]   peek_data  // Observation data, registered
);

  typedef struct packed {
    logic [DEPTH-1:0][data_move_pkg::DATA_W-1:0] mem;
    logic [data_move_pkg::DATA_W-1:0]            peek;
  } bank_state_type;

  bank_state_type state_r;
  bank_state_type state_nxt;

  // Write and peek next state
  always_comb begin
    state_nxt = state_r;
    if (wr_en) begin
      state_nxt.mem[wr_addr] = wr_data;
    end
    state_nxt.peek = state_r.mem[peek_addr];
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= '{mem: '{default: data_move_pkg::FILE_RESET}, peek: data_move_pkg::FILE_RESET};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs
  assign rd_data   = state_r.mem[rd_addr];
  assign peek_data = state_r.peek;

endmodule : file_reg_bank

`default_nettype wire

// *** rtl/data_move_instr_exec.sv ***
// Executes the copy, store, immediate-load and idle instructions
//
// Notes on behaviour
// RULE1 - Copy reads f; d selects accumulator or f
// RULE2 - Copy sets zero flag from moved value
// RULE3 - Store writes accumulator to f, flags untouched
// RULE4 - Immediate load puts literal in accumulator
// RULE5 - Software encodes load don't-care bits as zero
// RULE6 - One word, one cycle; idle changes nothing
`timescale 1ns/1ns
`default_nettype none

module data_move_instr_exec #(
  parameter int FILE_DEPTH = 128
) (
  input  wire logic                                core_clk,     // Core instruction clock
  input  wire logic                                reset,        // Async reset, active high
  input  wire logic                                instr_valid,  // Instruction word present
  input  wire logic [data_move_pkg::INSTR_W-1:0]   instr_word,   // Fetched instruction word
  output logic      [data_move_pkg::DATA_W-1:0]    accum,        // Accumulator
  output logic                                     zero_flag,    // Zero status flag
  output logic                                     op_done,      // Pulse: instruction retired
  output data_move_pkg::op_type                    op_kind,      // Kind of last instruction
  output logic                                     file_wr_seen, // Pulse: file register written
  output logic      [data_move_pkg::ADDR_W-1:0]    file_wr_addr, // Address of last file write
  output logic      [data_move_pkg::DATA_W-1:0]    file_wr_data, // Data of last file write
  output logic                                     dc_bits_set,  // Pulse: load had nonzero don't-cares
  output logic                                     unsupported,  // Pulse: word outside this group
  output logic      [data_move_pkg::COUNT_W-1:0]   retired_count,// Instructions of this group retired
  input  wire logic [data_move_pkg::ADDR_W-1:0]    peek_addr,    // File register to observe
  output logic      [data_move_pkg::DATA_W-1:0]    peek_data     // Observed file register
);

  typedef struct packed {
    logic [data_move_pkg::DATA_W-1:0]  accum;
    logic                              zero;
    logic                              done;
    data_move_pkg::op_type             kind;
    logic                              wr_seen;
    logic [data_move_pkg::ADDR_W-1:0]  wr_addr;
    logic [data_move_pkg::DATA_W-1:0]  wr_data;
    logic                              dc_err;
    logic                              unsup;
    logic [data_move_pkg::COUNT_W-1:0] count;
  } exec_state_type;

  exec_state_type state_r;
  exec_state_type state_nxt;

  // Bank port signals
  logic                             bank_wr_en;
  logic [data_move_pkg::ADDR_W-1:0] bank_wr_addr;
  logic [data_move_pkg::DATA_W-1:0] bank_wr_data;
  logic [data_move_pkg::ADDR_W-1:0] bank_rd_addr;
  logic [data_move_pkg::DATA_W-1:0] bank_rd_data;

  // Decoded fields of the current word
  data_move_pkg::op_type            cur_op;
  logic [data_move_pkg::ADDR_W-1:0] file_addr;
  logic [data_move_pkg::DATA_W-1:0] literal;
  logic                             dest_file;

  // Matches a word against one opcode mask and pattern
  function automatic logic op_match(
    input logic [data_move_pkg::INSTR_W-1:0] word,
    input logic [data_move_pkg::INSTR_W-1:0] mask,
    input logic [data_move_pkg::INSTR_W-1:0] pattern
  );
    op_match = ((word & mask) == pattern);
  endfunction : op_match

  // Classifies an instruction word
  function automatic data_move_pkg::op_type decode_op(
    input logic [data_move_pkg::INSTR_W-1:0] word
  );
    if (op_match(word, data_move_pkg::COPY_MASK, data_move_pkg::COPY_PATTERN)) begin
      decode_op = data_move_pkg::OP_COPY;
    end else if (op_match(word, data_move_pkg::STORE_MASK, data_move_pkg::STORE_PATTERN)) begin
      decode_op = data_move_pkg::OP_STORE;
    end else if (op_match(word, data_move_pkg::LOAD_MASK, data_move_pkg::LOAD_PATTERN)) begin
      decode_op = data_move_pkg::OP_LOAD;
    end else if (op_match(word, data_move_pkg::IDLE_MASK, data_move_pkg::IDLE_PATTERN)) begin
      decode_op = data_move_pkg::OP_IDLE;
    end else begin
      decode_op = data_move_pkg::OP_OTHER;
    end
  endfunction : decode_op

  // Field extraction
  assign cur_op    = decode_op(instr_word);
  assign file_addr = instr_word[data_move_pkg::FILE_LSB +: data_move_pkg::ADDR_W]; // RULE1
  assign literal   = instr_word[data_move_pkg::LIT_LSB +: data_move_pkg::DATA_W];  // RULE4
  assign dest_file = instr_word[data_move_pkg::DEST_BIT];
  assign bank_rd_addr = file_addr;

  // Bank write port, driven in the cycle the word is taken
  always_comb begin
    bank_wr_en   = 1'b0;
    bank_wr_addr = file_addr;
    bank_wr_data = state_r.accum;
    if (instr_valid) begin
      unique case (cur_op)
        data_move_pkg::OP_COPY: begin
          if (dest_file != data_move_pkg::DEST_ACCUM) begin
            bank_wr_en   = 1'b1;           // RULE1
            bank_wr_data = bank_rd_data;   // RULE1
          end
        end
        data_move_pkg::OP_STORE: begin
          bank_wr_en   = 1'b1;             // RULE3
          bank_wr_data = state_r.accum;    // RULE3
        end
        data_move_pkg::OP_NONE,
        data_move_pkg::OP_LOAD,
        data_move_pkg::OP_IDLE,
        data_move_pkg::OP_OTHER: begin
          bank_wr_en = 1'b0;               // RULE6
        end
      endcase
    end
  end

  // Execution next state: every instruction finishes in one cycle
  always_comb begin
    state_nxt         = state_r;
    state_nxt.done    = 1'b0;
    state_nxt.wr_seen = 1'b0;
    state_nxt.dc_err  = 1'b0;
    state_nxt.unsup   = 1'b0;
    if (instr_valid) begin
      state_nxt.kind = cur_op;
      if (cur_op != data_move_pkg::OP_OTHER) begin
        state_nxt.done  = 1'b1;                                            // RULE6
        state_nxt.count = state_r.count + data_move_pkg::COUNT_STEP;
      end
      unique case (cur_op)
        data_move_pkg::OP_COPY: begin
          if (dest_file == data_move_pkg::DEST_ACCUM) begin
            state_nxt.accum = bank_rd_data;                                // RULE1
          end
          state_nxt.zero = (bank_rd_data == '0);                           // RULE2
        end
        data_move_pkg::OP_STORE: begin
          state_nxt.accum = state_r.accum;                                 // RULE3
        end
        data_move_pkg::OP_LOAD: begin
          state_nxt.accum  = literal;                                      // RULE4
          state_nxt.dc_err = |(instr_word & data_move_pkg::LOAD_DC_MASK);  // RULE5
        end
        data_move_pkg::OP_IDLE: begin
          state_nxt.accum = state_r.accum;                                 // RULE6
        end
        data_move_pkg::OP_NONE: begin
          state_nxt.accum = state_r.accum;
        end
        data_move_pkg::OP_OTHER: begin
          state_nxt.unsup = 1'b1;
        end
      endcase
      if (bank_wr_en) begin
        state_nxt.wr_seen = 1'b1;
        state_nxt.wr_addr = bank_wr_addr;
        state_nxt.wr_data = bank_wr_data;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r.accum   <= data_move_pkg::ACCUM_RESET;
      state_r.zero    <= data_move_pkg::ZERO_RESET;
      state_r.done    <= 1'b0;
      state_r.kind    <= data_move_pkg::OP_NONE;
      state_r.wr_seen <= 1'b0;
      state_r.wr_addr <= '0;
      state_r.wr_data <= data_move_pkg::FILE_RESET;
      state_r.dc_err  <= 1'b0;
      state_r.unsup   <= 1'b0;
      state_r.count   <= data_move_pkg::COUNT_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // File register bank
  file_reg_bank #(
    .DEPTH (FILE_DEPTH)
  ) u_bank (
    .core_clk  (core_clk),
    .reset     (reset),
    .wr_en     (bank_wr_en),
    .wr_addr   (bank_wr_addr),
    .wr_data   (bank_wr_data),
    .rd_addr   (bank_rd_addr),
    .rd_data   (bank_rd_data),
    .peek_addr (peek_addr),
    .peek_data (peek_data)
  );

  // Outputs
  assign accum         = state_r.accum;
  assign zero_flag     = state_r.zero;
  assign op_done       = state_r.done;
  assign op_kind       = state_r.kind;
  assign file_wr_seen  = state_r.wr_seen;
  assign file_wr_addr  = state_r.wr_addr;
  assign file_wr_data  = state_r.wr_data;
  assign dc_bits_set   = state_r.dc_err;
  assign unsupported   = state_r.unsup;
  assign retired_count = state_r.count;

endmodule : data_move_instr_exec

`default_nettype wire

// *** tb/data_move_sva.sv ***
// Port checks for the data-movement executor
`timescale 1ns/1ns
`default_nettype none
module data_move_sva (
  input wire logic        core_clk,      // Clock
  input wire logic        reset,         // Reset
  input wire logic        instr_valid,   // Word present
  input wire logic [13:0] instr_word,    // Word
  input wire logic [7:0]  accum,         // Accumulator
  input wire logic        zero_flag,     // Zero flag
  input wire logic        op_done,       // Retire pulse
  input wire logic        file_wr_seen,  // Write pulse
  input wire logic [6:0]  file_wr_addr,  // Write address
  input wire logic [7:0]  file_wr_data,  // Write data
  input wire logic        dc_bits_set,   // Don't-care pulse
  input wire logic        unsupported,   // Foreign word pulse
  input wire logic [15:0] retired_count  // Retire count
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic cp, st, ld, id;
  // Decode of the word on the port
  assign cp = instr_valid && (instr_word & data_move_pkg::COPY_MASK) == data_move_pkg::COPY_PATTERN;
  assign st = instr_valid && (instr_word & data_move_pkg::STORE_MASK) == data_move_pkg::STORE_PATTERN;
  assign ld = instr_valid && (instr_word & data_move_pkg::LOAD_MASK) == data_move_pkg::LOAD_PATTERN;
  assign id = instr_valid && (instr_word & data_move_pkg::IDLE_MASK) == data_move_pkg::IDLE_PATTERN;
  sequence s_back; cp && instr_word[7]; endsequence
  sequence s_wr; file_wr_seen ##0 $stable(zero_flag); endsequence
  property p_done; (cp || st || ld || id) |=> op_done && retired_count == $past(retired_count) + 16'h0001;
  endproperty
  property p_copy_acc; cp && !instr_word[7] |=> zero_flag == (accum == 8'h00) && !file_wr_seen; endproperty
  property p_copy_back; s_back |=> file_wr_seen && $stable(accum) && zero_flag == (file_wr_data == 8'h00);
  endproperty
  property p_store; st |=> s_wr ##0 file_wr_addr == $past(instr_word[6:0]) && file_wr_data == $past(accum);
  endproperty
  property p_load; ld |=> accum == $past(instr_word[7:0]) && $stable(zero_flag); endproperty
  property p_dc; ld && instr_word[9:8] != 2'b00 |=> dc_bits_set; endproperty
  property p_dc_clean; ld && instr_word[9:8] == 2'b00 |=> !dc_bits_set; endproperty
  property p_idle; id |=> $stable(accum) && $stable(zero_flag) && !file_wr_seen; endproperty
  property p_foreign; instr_valid && !(cp || st || ld || id) |=> unsupported && !op_done && $stable(accum);
  endproperty
  property p_quiet; !instr_valid |=> !op_done && !unsupported && $stable(retired_count); endproperty
  a_done: assert property (p_done) else $error("retire missing");
  a_copy_acc: assert property (p_copy_acc) else $error("copy to acc bad");
  a_copy_back: assert property (p_copy_back) else $error("copy back bad");
  a_store: assert property (p_store) else $error("store bad");
  a_load: assert property (p_load) else $error("load bad");
  a_dc: assert property (p_dc) else $error("dont-care flag missing");
  a_dc_clean: assert property (p_dc_clean) else $error("dont-care flag spurious");
  a_idle: assert property (p_idle) else $error("idle changed state");
  a_foreign: assert property (p_foreign) else $error("foreign word bad");
  a_quiet: assert property (p_quiet) else $error("activity without word");
endmodule : data_move_sva
`default_nettype wire

// *** tb/prog_feed.sv ***
// Program memory feed: one instruction word per cycle
`timescale 1ns/1ns
`default_nettype none
module prog_feed (
  input  wire logic        core_clk,    // Core clock
  output var  logic        instr_valid, // Word present
  output var  logic [13:0] instr_word   // Word
);
  initial begin
    instr_valid = 1'b0;
    instr_word  = 14'h0000;
  end
  // Present a word; load don't-cares cleared unless raw
  task issue(input logic [13:0] w, input logic raw);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    if (!raw && (w & data_move_pkg::LOAD_MASK) == data_move_pkg::LOAD_PATTERN)
      instr_word <= w & ~data_move_pkg::LOAD_DC_MASK;
    else
      instr_word <= w;
  endtask : issue
  // Release after the last word is taken; stale word inverted
  task fin();
    @(posedge core_clk);
    instr_valid <= 1'b0;
    instr_word  <= ~instr_word;
    #1;
  endtask : fin
endmodule : prog_feed
`default_nettype wire

// *** tb/data_move_instr_exec_test.sv ***
// Self-checking bench for the data-movement executor
`timescale 1ns/1ns
`default_nettype none
module data_move_instr_exec_test;
  logic core_clk, reset, instr_valid, zero_flag, op_done, file_wr_seen, dc_bits_set, unsupported;
  logic [13:0] instr_word;
  logic [7:0]  accum, file_wr_data, peek_data;
  logic [6:0]  file_wr_addr, peek_addr;
  logic [15:0] retired_count;
  data_move_pkg::op_type op_kind;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  data_move_instr_exec dut (.core_clk(core_clk), .reset(reset), .instr_valid(instr_valid),
    .instr_word(instr_word), .accum(accum), .zero_flag(zero_flag), .op_done(op_done), .op_kind(op_kind),
    .file_wr_seen(file_wr_seen), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .dc_bits_set(dc_bits_set), .unsupported(unsupported), .retired_count(retired_count),
    .peek_addr(peek_addr), .peek_data(peek_data));
  prog_feed feed (.core_clk(core_clk), .instr_valid(instr_valid), .instr_word(instr_word));
  // Clock generation
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      give_verdict();
    end
  end
  task give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task run(input logic [13:0] w);
    feed.issue(w, 1'b0);
    feed.fin();
  endtask : run
  task peek(input logic [6:0] a, input logic [7:0] e);
    @(posedge core_clk);
    peek_addr <= a;
    @(posedge core_clk);
    #1;
    chk(peek_data, e);
  endtask : peek
  task t_reset();
    chk(accum, 8'h00);
    chk(zero_flag, 1'b0);
    chk(op_kind, data_move_pkg::OP_NONE);
    peek(7'h7f, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task t_load();
    run(14'h0810);
    chk(zero_flag, 1'b1);
    chk(op_kind, data_move_pkg::OP_COPY);
    run(14'h305a);
    chk(accum, 8'h5a);
    chk(zero_flag, 1'b1);
    feed.issue(14'h33ff, 1'b1);
    feed.fin();
    chk(dc_bits_set, 1'b1);
    chk(accum, 8'hff);
    $display("test load done");
  endtask : t_load
  task t_store();
    run(14'h00ff);
    chk({file_wr_seen, file_wr_addr, file_wr_data}, 16'hffff);
    chk(zero_flag, 1'b1);
    peek(7'h7f, 8'hff);
    feed.issue(14'h0080, 1'b0);
    feed.issue(14'h0800, 1'b0);
    feed.fin();
    chk({accum, 7'h00, zero_flag}, 16'hff00);
    run(14'h0890);
    chk({file_wr_seen, file_wr_addr, file_wr_data}, 16'h9000);
    chk({accum, 7'h00, zero_flag}, 16'hff01);
    peek(7'h00, 8'hff);
    $display("test store and copy done");
  endtask : t_store
  task t_idle();
    run(14'h0060);
    chk({op_done, file_wr_seen, zero_flag}, 3'b101);
    chk(op_kind, data_move_pkg::OP_IDLE);
    chk(accum, 8'hff);
    run(14'h3fff);
    chk({unsupported, op_done}, 2'b10);
    chk(retired_count, 16'h0008);
    $display("test idle and foreign done");
  endtask : t_idle
  // Reset in mid-run clears core and bank; first word right after release
  task t_rerun();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(retired_count, 16'h0000);
    chk({accum, 7'h00, zero_flag}, 16'h0000);
    @(posedge core_clk);
    reset <= 1'b0;
    run(14'h3042);
    chk({accum, 7'h00, zero_flag}, 16'h4200);
    chk(retired_count, 16'h0001);
    peek(7'h7f, 8'h00);
    $display("test mid-run reset done");
  endtask : t_rerun
  // Main sequence
  initial begin
    reset     = 1'b1;
    peek_addr = 7'h00;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    t_reset();
    t_load();
    t_store();
    t_idle();
    t_rerun();
    give_verdict();
  end
endmodule : data_move_instr_exec_test
bind data_move_instr_exec data_move_sva chk_i (.core_clk(core_clk), .reset(reset), .instr_valid(instr_valid),
  .instr_word(instr_word), .accum(accum), .zero_flag(zero_flag), .op_done(op_done),
  .file_wr_seen(file_wr_seen), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
  .dc_bits_set(dc_bits_set), .unsupported(unsupported), .retired_count(retired_count));
`default_nettype wire
